// >>> scd_pkg.sv
package scd_pkg;
    localparam int FRAME_BITS = 16;
    // Frame bit positions
    localparam int BIT_MODE_HI = 15;
    localparam int BIT_MODE_LO = 14;
    localparam int BIT_PARITY = 13;
    localparam int BIT_RW = 12;
    localparam int BIT_SWR = 11;
    localparam int BIT_SEL = 10;
    localparam int BIT_LVL_HI = 9;
    localparam int BIT_LVL_LO = 8;
    // Response words and patterns
    localparam logic [15:0] RSP_POR = 16'h0000;
    localparam logic [15:0] RSP_PARITY_ERR = 16'hD000;
    localparam logic [15:0] RSP_COUNT_ERR = 16'hD003;
    localparam logic [15:0] RSP_RESET_DONE = 16'h2003;
    localparam logic [15:0] RSP_RESET_STEP1 = 16'h1802;
    localparam logic [15:0] RSP_CFG1_LOW = 16'h0002;
    localparam logic [7:0] RST_KEY1 = 8'hAA;
    localparam logic [7:0] RST_KEY2 = 8'h55;
    localparam logic [1:0] LEVEL_RESET = 2'h0;
    localparam logic [1:0] LATCH_RESET = 2'h0;
    // Latch durations in ms
    localparam int LATCH_MS_1 = 128;
    localparam int LATCH_MS_2 = 256;
    localparam int LATCH_MS_3 = 512;
    localparam int CLK_MHZ = 100;
    localparam int MS_NS = 1000000;
    localparam int CLK_NS = 1000 / CLK_MHZ;
    localparam int CYC_PER_MS = MS_NS / CLK_NS;
    localparam int NUM_FEN = 4;

    typedef struct packed {
        logic [1:0] sclkSync;
        logic [1:0] csSync;
        logic [1:0] mosiSync;
        logic sclkPrev;
        logic [15:0] shiftIn;
        logic [15:0] shiftOut;
        logic [4:0] bitCount;
        logic [15:0] pendingRsp;
        logic [1:0] level;
        logic [1:0] latchSel;
        logic keyArmed;
        logic resetStatus;
        logic [16:0] msDiv;
        logic msTick;
        logic [3:0][1:0] fenSync;
        logic [3:0] fenPrev;
        logic [3:0][9:0] fenTimer;
        logic [3:0] fenOut;
        logic misoOut;
    } scd_state_s;
endpackage

// >>> scd_config_decoder.sv
`timescale 1ns/10ps
module scd_config_decoder
    import scd_pkg::*;
#(
    parameter int CYC_MS = CYC_PER_MS
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic spiSclk,
    input wire logic spiCsN,
    input wire logic spiMosi,
    input wire logic [NUM_FEN-1:0] fire_enable_input,
    output logic spiMiso,
    output logic [1:0] firing_current_level,
    output logic [NUM_FEN-1:0] fire_enable,
    output logic softResetPulse
);
    scd_state_s st_r;
    scd_state_s st_nxt;
    logic rstPulse_r;
    logic rstPulse_nxt;
    logic frameFull;

    function automatic logic [15:0] withParity(input logic [15:0] w);
        logic [15:0] r;
        r = w;
        r[BIT_PARITY] = 1'b0;
        r[BIT_PARITY] = ~(^r);
        return r;
    endfunction

    function automatic logic [9:0] latchMs(input logic [1:0] sel);
        logic [9:0] v;
        v = 10'h000;
        unique case (sel)
            2'h1: v = 10'(LATCH_MS_1);
            2'h2: v = 10'(LATCH_MS_2);
            2'h3: v = 10'(LATCH_MS_3);
            default: v = 10'h000;
        endcase
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic: sampling, frame decode, timers
    always_comb begin
        logic [15:0] f;
        logic [15:0] rsp;
        logic sclkRise;
        logic sclkFall;
        logic csRise;
        logic csFall;
        logic doReset;
        // bitCount is 0x1F while idle between frames and 0x1E once a frame runs past 16 clocks
        f = 16'h0000;
        rsp = 16'h0000;
        doReset = 1'b0;
        rstPulse_nxt = 1'b0;
        sclkRise = st_r.sclkSync[1] & ~st_r.sclkPrev;
        sclkFall = ~st_r.sclkSync[1] & st_r.sclkPrev;
        // Chip select edges come from the idle marker, which saves a previous-value bit
        csFall = !st_r.csSync[1] && st_r.bitCount == 5'h1F;
        csRise = st_r.csSync[1] && st_r.bitCount != 5'h1F;
        st_nxt = st_r;
        st_nxt.sclkSync = {st_r.sclkSync[0], spiSclk};
        st_nxt.csSync = {st_r.csSync[0], spiCsN};
        st_nxt.mosiSync = {st_r.mosiSync[0], spiMosi};
        st_nxt.sclkPrev = st_r.sclkSync[1];
        // Frame start: load pending response
        if (csFall) begin
            st_nxt.shiftOut = st_r.pendingRsp;
            st_nxt.misoOut = st_r.pendingRsp[FRAME_BITS-1];
            st_nxt.bitCount = 5'h00;
        end else if (!st_r.csSync[1]) begin
            if (sclkRise && st_r.bitCount != 5'h1E) begin
                st_nxt.shiftIn = {st_r.shiftIn[14:0], st_r.mosiSync[1]};
                st_nxt.bitCount = (st_r.bitCount == 5'h10) ? 5'h1E : 5'(st_r.bitCount + 5'h01);
            end
            if (sclkFall) begin
                st_nxt.shiftOut = {st_r.shiftOut[14:0], 1'b0};
                st_nxt.misoOut = st_r.shiftOut[14];
            end
        end
        // Frame end: decode the received word
        if (csRise) begin
            st_nxt.bitCount = 5'h1F;
            st_nxt.misoOut = 1'b0;
            f = st_r.shiftIn;
            if (st_r.bitCount != 5'h10) begin
                rsp = RSP_COUNT_ERR;
                st_nxt.keyArmed = 1'b0;
            end else if (~(^f)) begin
                rsp = RSP_PARITY_ERR;
                st_nxt.keyArmed = 1'b0;
            end else if (f[BIT_MODE_HI] || f[BIT_MODE_LO]) begin
                rsp = st_r.pendingRsp; // Other commands belong to other blocks
                st_nxt.keyArmed = 1'b0;
            end else if (!f[BIT_SEL]) begin
                st_nxt.keyArmed = 1'b0;
                if (f[BIT_RW] && !f[BIT_SWR]) begin
                    st_nxt.level = f[BIT_LVL_HI:BIT_LVL_LO];
                end else if (f[BIT_RW] && f[BIT_SWR]) begin
                    if (st_r.keyArmed && f[7:0] == RST_KEY2) begin
                        doReset = 1'b1;
                    end else if (f[7:0] == RST_KEY1) begin
                        st_nxt.keyArmed = 1'b1;
                    end
                end
                // header echoed, level as held once this frame is applied
                rsp = {f[15:10], st_nxt.level, RSP_CFG1_LOW[7:0]};
                rsp[0] = st_r.resetStatus;
                if (st_nxt.keyArmed) begin
                    rsp = RSP_RESET_STEP1 | {6'h00, st_r.level, 8'h00};
                end
            end else if (!f[BIT_SWR]) begin
                st_nxt.keyArmed = 1'b0;
                if (f[BIT_RW]) begin
                    st_nxt.latchSel = f[BIT_LVL_HI:BIT_LVL_LO];
                end
                rsp = {f[15:10], st_nxt.latchSel, 8'h00};
            end else begin
                rsp = st_r.pendingRsp;
                st_nxt.keyArmed = 1'b0;
            end
            // An ignored frame repeats the pending word untouched, so the power-on 0x0000 survives it
            st_nxt.pendingRsp = (rsp == st_r.pendingRsp) ? rsp : withParity(rsp);
            if (doReset) begin
                // settings, key, timers and divider back to reset values, status bit set, then the done word
                st_nxt.level = LEVEL_RESET;
                st_nxt.latchSel = LATCH_RESET;
                st_nxt.keyArmed = 1'b0;
                st_nxt.fenTimer = '0;
                st_nxt.fenOut = '0;
                st_nxt.msDiv = '0;
                st_nxt.resetStatus = 1'b1;
                st_nxt.pendingRsp = RSP_RESET_DONE;
                rstPulse_nxt = 1'b1;
            end
        end
        // Millisecond tick from mclk
        st_nxt.msTick = 1'b0;
        if (!doReset) begin
            if (st_r.msDiv == 17'(CYC_MS - 1)) begin
                st_nxt.msDiv = '0;
                st_nxt.msTick = 1'b1;
            end else begin
                st_nxt.msDiv = 17'(st_r.msDiv + 17'h00001);
            end
        end
        // Pulse-stretch timers: latch value sampled at start
        for (int i = 0; i < NUM_FEN; i++) begin
            st_nxt.fenSync[i] = {st_r.fenSync[i][0], fire_enable_input[i]};
            st_nxt.fenPrev[i] = st_r.fenSync[i][1];
            if (!doReset) begin
                if (st_r.fenSync[i][1] && !st_r.fenPrev[i]) begin
                    st_nxt.fenTimer[i] = latchMs(st_r.latchSel);
                    st_nxt.fenOut[i] = 1'b1;
                end else if (st_r.fenSync[i][1]) begin
                    st_nxt.fenOut[i] = 1'b1;
                end else if (st_r.fenTimer[i] != 10'h000) begin
                    st_nxt.fenOut[i] = 1'b1;
                    if (st_r.msTick) begin
                        st_nxt.fenTimer[i] = 10'(st_r.fenTimer[i] - 10'h001);
                    end
                end else begin
                    st_nxt.fenOut[i] = 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register; reset response is 0x0000
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.bitCount <= 5'h1F;
            st_r.sclkSync <= 2'h0;
            st_r.csSync <= 2'h3;
            st_r.pendingRsp <= RSP_POR;
            rstPulse_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            rstPulse_r <= rstPulse_nxt;
        end
    end

    assign spiMiso = st_r.misoOut;
    assign firing_current_level = st_r.level;
    assign fire_enable = st_r.fenOut;
    assign softResetPulse = rstPulse_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    a_reset_done_word: assert property (@(posedge mclk) disable iff (!rst_n)
        rstPulse_r |-> st_r.pendingRsp == RSP_RESET_DONE && st_r.level == LEVEL_RESET)
        else $error("reset done word wrong");
    a_latch_reset_val: assert property (@(posedge mclk) disable iff (!rst_n)
        rstPulse_r |-> st_r.latchSel == LATCH_RESET && st_r.fenOut == '0)
        else $error("latch not cleared");
    a_resp_odd_parity: assert property (@(posedge mclk) disable iff (!rst_n)
        $changed(st_r.pendingRsp) && !rstPulse_r |-> ^st_r.pendingRsp)
        else $error("response parity even");
    a_status_bit_set: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(st_r.resetStatus) |-> rstPulse_r)
        else $error("status set without reset");
    a_level_hold_read: assert property (@(posedge mclk) disable iff (!rst_n)
        $changed(st_r.level) |-> rstPulse_r || $past(st_r.bitCount) == 5'h10)
        else $error("level changed outside frame");
    a_fen_stretch_on: assert property (@(posedge mclk) disable iff (!rst_n)
        st_r.fenTimer[0] != 10'h000 && !rstPulse_r |=> st_r.fenOut[0] || rstPulse_r)
        else $error("stretch output dropped");
    a_reset_needs_key: assert property (@(posedge mclk) disable iff (!rst_n)
        rstPulse_r |-> $past(st_r.keyArmed))
        else $error("reset without first key");
    a_tick_period: assert property (@(posedge mclk) disable iff (!rst_n)
        st_r.msTick |=> !st_r.msTick)
        else $error("tick too often");
    c_soft_reset: cover property (@(posedge mclk) disable iff (!rst_n) rstPulse_r);
    c_key_armed: cover property (@(posedge mclk) disable iff (!rst_n) $rose(st_r.keyArmed));
    c_level_write: cover property (@(posedge mclk) disable iff (!rst_n) $changed(st_r.level));
    c_fen_stretch: cover property (@(posedge mclk) disable iff (!rst_n) $fell(st_r.fenOut[0]));
    c_count_error: cover property (@(posedge mclk) disable iff (!rst_n) st_r.pendingRsp == RSP_COUNT_ERR);

    // Frame judgement: frameFull marks the cycle in which a frame of exactly 16 clocks is decoded
    assign frameFull = st_r.csSync[1] && st_r.bitCount == 5'h10;
    a_load_pending_rsp: assert property (@(posedge mclk) disable iff (!rst_n)
        !st_r.csSync[1] && st_r.bitCount == 5'h1F |=> st_r.shiftOut == $past(st_r.pendingRsp))
        else $error("pending answer not loaded at frame start");
    a_miso_idle_low: assert property (@(posedge mclk) disable iff (!rst_n)
        st_r.csSync[1] && st_r.bitCount == 5'h1F |-> !st_r.misoOut)
        else $error("serial output not low between frames");
    a_count_err_word: assert property (@(posedge mclk) disable iff (!rst_n)
        st_r.csSync[1] && st_r.bitCount != 5'h1F && st_r.bitCount != 5'h10
        |=> st_r.pendingRsp == RSP_COUNT_ERR)
        else $error("wrong clock count not reported");
    a_parity_err_word: assert property (@(posedge mclk) disable iff (!rst_n)
        frameFull && !(^st_r.shiftIn) |=> st_r.pendingRsp == RSP_PARITY_ERR)
        else $error("parity error not reported");

    // Configuration decode: the received word stays in shiftIn until the next frame starts
    a_read_keeps_cfg: assert property (@(posedge mclk) disable iff (!rst_n)
        frameFull && !st_r.shiftIn[BIT_RW] |=> $stable(st_r.level) && $stable(st_r.latchSel))
        else $error("read frame changed a setting");
    a_level_write_val: assert property (@(posedge mclk) disable iff (!rst_n)
        frameFull && ^st_r.shiftIn && st_r.shiftIn[15:14] == 2'h0 && st_r.shiftIn[12:10] == 3'h4
        |=> st_r.level == st_r.shiftIn[BIT_LVL_HI:BIT_LVL_LO])
        else $error("current level not written");
    a_latch_write_val: assert property (@(posedge mclk) disable iff (!rst_n)
        frameFull && ^st_r.shiftIn && st_r.shiftIn[15:14] == 2'h0 && st_r.shiftIn[12:10] == 3'h5
        |=> st_r.latchSel == st_r.shiftIn[BIT_LVL_HI:BIT_LVL_LO])
        else $error("latch setting not written");
    a_level_read_rsp: assert property (@(posedge mclk) disable iff (!rst_n)
        frameFull && ^st_r.shiftIn && st_r.shiftIn[15:14] == 2'h0
        && !st_r.shiftIn[BIT_RW] && !st_r.shiftIn[BIT_SEL]
        |=> st_r.pendingRsp[9:8] == st_r.level && st_r.pendingRsp[7:1] == RSP_CFG1_LOW[7:1])
        else $error("level read answer wrong");
    a_latch_rsp_low: assert property (@(posedge mclk) disable iff (!rst_n)
        frameFull && ^st_r.shiftIn && st_r.shiftIn[15:14] == 2'h0 && st_r.shiftIn[11:10] == 2'h1
        |=> st_r.pendingRsp[9:8] == st_r.latchSel && st_r.pendingRsp[7:0] == 8'h00)
        else $error("latch answer wrong");
    a_step_one_word: assert property (@(posedge mclk) disable iff (!rst_n)
        frameFull && ^st_r.shiftIn && st_r.shiftIn[15:14] == 2'h0 && st_r.shiftIn[12:10] == 3'h6
        && st_r.shiftIn[7:0] == RST_KEY1
        |=> st_r.keyArmed && st_r.pendingRsp[12:8] == {3'h6, st_r.level}
        && st_r.pendingRsp[7:0] == RSP_RESET_STEP1[7:0])
        else $error("first key answer wrong");
    a_status_after_rst: assert property (@(posedge mclk) disable iff (!rst_n)
        rstPulse_r |-> st_r.resetStatus)
        else $error("status not set after reset");

    // Pulse stretch: each timer follows only its own input
    a_stretch_ends: assert property (@(posedge mclk) disable iff (!rst_n)
        st_r.fenTimer[1] == 10'h000 && !st_r.fenSync[1][1] |=> !st_r.fenOut[1])
        else $error("stretch output stuck high");
    a_fen_follows_in: assert property (@(posedge mclk) disable iff (!rst_n)
        st_r.fenSync[2][1] |=> st_r.fenOut[2] || rstPulse_r)
        else $error("output low while input high");
    a_latch_sampled: assert property (@(posedge mclk) disable iff (!rst_n)
        st_r.fenSync[3][1] && !st_r.fenPrev[3]
        |=> st_r.fenTimer[3] == latchMs($past(st_r.latchSel)) || rstPulse_r)
        else $error("timer not loaded from setting");
endmodule // scd_config_decoder

// >>> scd_host_model.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Host master on the deploy serial port: clock idles low and stands still between frames
module scd_host_model
    import scd_pkg::*;
(
    input wire logic mclk,
    output logic spiSclk,
    output logic spiCsN,
    output logic spiMosi,
    input wire logic spiMiso
);
    // Whole mclk cycles, then step off the edge so nothing races the sampler
    task automatic waitCyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // Parity bit chosen so the whole word has an odd count of ones
    function automatic logic [15:0] withParity(input logic [15:0] w);
        logic [15:0] v;
        v = w;
        v[BIT_PARITY] = 1'b0;
        v[BIT_PARITY] = ~^v;
        return v;
    endfunction

    // One frame, MSB first; nBits below 16 makes a short frame on purpose
    task automatic xfer(input logic [15:0] word, input int nBits, output logic [15:0] rsp);
        rsp = 16'h0000;
        spiCsN = 1'b0;
        waitCyc(8);
        for (int i = 15; i > 15 - nBits; i--) begin
            spiMosi = word[i];
            waitCyc(8);
            rsp = {rsp[14:0], spiMiso}; // Device shifts on falling, so data is settled here
            spiSclk = 1'b1;
            waitCyc(8);
            spiSclk = 1'b0;
        end
        waitCyc(8);
        spiCsN = 1'b1;
        spiMosi = ~spiMosi; // Released line must not keep showing the last bit
        waitCyc(8);
    endtask

    // Idle levels at time zero
    initial begin
        spiSclk = 1'b0;
        spiCsN = 1'b1;
        spiMosi = 1'b0;
    end
endmodule // scd_host_model

// >>> squib_config_command_decoder_test.sv
`timescale 1ns/10ps
`define SCD_CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin bad_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
////////////////////////////////////////////////////////////////////////////////
module squib_config_command_decoder_test;
    import scd_pkg::*;
    logic mclk;
    logic rst_n;
    logic spiSclk;
    logic spiCsN;
    logic spiMosi;
    logic spiMiso;
    logic [NUM_FEN-1:0] fenIn;
    logic [NUM_FEN-1:0] fenOut;
    logic [1:0] level;
    logic softResetPulse;
    logic [15:0] rsp;
    int bad_count;
    int samples_checked;
    int pulseCount;

    // Ten cycles per ms keeps the 128 ms stretch short in simulation
    scd_config_decoder #(.CYC_MS(10)) dut (
        .mclk(mclk), .rst_n(rst_n), .spiSclk(spiSclk), .spiCsN(spiCsN), .spiMosi(spiMosi),
        .fire_enable_input(fenIn), .spiMiso(spiMiso), .firing_current_level(level),
        .fire_enable(fenOut), .softResetPulse(softResetPulse)
    );
    scd_host_model host (
        .mclk(mclk), .spiSclk(spiSclk), .spiCsN(spiCsN), .spiMosi(spiMosi), .spiMiso(spiMiso)
    );

    // Clock and soft-reset pulse counter
    always #5 mclk = ~mclk;
    always @(posedge mclk) begin
        if (softResetPulse === 1'b1) pulseCount++;
    end

    // Full well-formed frame; rsp holds the answer to the previous frame
    task automatic send(input logic [15:0] w);
        host.xfer(host.withParity(w), 16, rsp);
    endtask

    task automatic summarize();
        $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Main sequence
    initial begin
        mclk = 1'b0;
        rst_n = 1'b0;
        fenIn = '0;
        bad_count = 0;
        samples_checked = 0;
        pulseCount = 0;
        repeat (10) @(posedge mclk);
        #1 rst_n = 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        send(16'h0000);
        `SCD_CHK(rsp, RSP_POR)
        // Every level code; the read carries junk level and low bits that must be ignored
        for (int l = 0; l < 4; l++) begin
            send(16'h1000 | (16'(l) << 8));
            `SCD_CHK(level, 2'(l))
            send(16'h03FF);
            `SCD_CHK(rsp, host.withParity(16'h1002 | (16'(l) << 8)))
            send(16'h0000);
            `SCD_CHK(rsp, host.withParity(16'h0002 | (16'(l) << 8)))
            `SCD_CHK(level, 2'(l))
        end
        // Latch setting 128 ms, written then read back
        send(16'h1500);
        send(16'h0400);
        `SCD_CHK(rsp, host.withParity(16'h1500))
        send(16'h0000);
        `SCD_CHK(rsp, host.withParity(16'h0500))
        // 128 ms stretch, about 1280 cycles from each input's own fall; inputs 0, 2, 3 fall 620 cycles later
        fenIn = 4'h2;
        repeat (20) @(posedge mclk);
        #1 fenIn = 4'h0;
        repeat (600) @(posedge mclk);
        #1 fenIn = 4'hD;
        repeat (20) @(posedge mclk);
        #1 fenIn = 4'h0;
        repeat (580) @(posedge mclk);
        #1 `SCD_CHK(fenOut, 4'hF)
        repeat (200) @(posedge mclk);
        #1 `SCD_CHK(fenOut, 4'hD)
        repeat (600) @(posedge mclk);
        #1 `SCD_CHK(fenOut, 4'h0)
        // Bad parity, then a short frame
        host.xfer(host.withParity(16'h0000) ^ 16'h2000, 16, rsp);
        send(16'h0000);
        `SCD_CHK(rsp, RSP_PARITY_ERR)
        host.xfer(host.withParity(16'h0000), 15, rsp);
        send(16'h0000);
        `SCD_CHK(rsp, RSP_COUNT_ERR)
        // Broken key sequence must not reset; the host then starts over
        send(16'h18AA);
        send(16'h0000);
        `SCD_CHK(rsp, host.withParity(16'h1B02))
        send(16'h1855);
        `SCD_CHK(pulseCount, 0)
        `SCD_CHK(level, 2'h3)
        send(16'h18AA);
        send(16'h1855);
        `SCD_CHK(pulseCount, 1)
        `SCD_CHK(level, LEVEL_RESET)
        send(16'h0400);
        `SCD_CHK(rsp, RSP_RESET_DONE)
        send(16'h0000);
        `SCD_CHK(rsp, host.withParity(16'h0400))
        send(16'h0000);
        `SCD_CHK(rsp, host.withParity(16'h0003))
        summarize();
    end

    // Watchdog well beyond the expected run of about 100 us
    initial begin
        #300000;
        bad_count++;
        summarize();
    end
endmodule // squib_config_command_decoder_test
